// ==== verilog/sfoc_regs.vh ====
// Behaviour
// - Low-power bit stops the sensor; page 0 0xF7-0xFD access then hangs it.
// - Restart truncates the frame; first valid frame follows after integration time.
// - Restart is a write-one trigger that always reads back zero.
// - Soft reset truncates frame, idles pins, returns other registers to defaults.
// - Clearing soft reset resumes normal frame generation and output.
// - Early fall off: frame-valid falls six pixel clocks after last line-valid.
// - Early fall on: frame-valid falls early; line-valid still for every active row.
// - Early fall lead is (1 + field) row times plus constant 3.
// - Early rise off: frame-valid rises six pixel clocks before first line-valid.
// - Early rise lead is (1 + field) row times plus horizontal blank plus 3.
// - Context-B read-mode fields act only when context select bit 3 is one.
// - Context-B binning bit one enables binning; zero gives normal readout.
// - Zoom follows each row with zoom-1 equal blank rows, own line-valid, zero data.
// - Zoom keeps pixel clock; each pixel held for zoom pixel clocks.
// - Zoom field 00/01/10/11 selects 2x/4x/8x/16x.
// - Single-converter bit halves readout rate; readout advances on every other pixel clock.
// - Update-hold keeps frame-synced writes pending; release applies at next frame start.
// - Bad frames after readout changes suppressed unless show-bad-frames is set.
`ifndef SFOC_REGS_VH
`define SFOC_REGS_VH
`define SFOC_ADDR_RESET 8'h0D
`define SFOC_ADDR_STROBE 8'h30
`define SFOC_ADDR_RMB 8'h20
`define SFOC_ADDR_CTXSEL 8'hF2
`define SFOC_HANG_LO 8'hF7
`define SFOC_HANG_HI 8'hFD
`define SFOC_RST_DEFAULT 16'h0000
`define SFOC_STROBE_DEFAULT 16'h0000
`define SFOC_RMB_DEFAULT 16'h0000
`define SFOC_CTX_DEFAULT 16'h0000
`define SFOC_B_HOLD 15
`define SFOC_B_SHOWBAD 8
`define SFOC_B_STBY 2
`define SFOC_B_RESTART 1
`define SFOC_B_SOFTRST 0
`define SFOC_B_FALL_EN 15
`define SFOC_F_FALL_HI 14
`define SFOC_F_FALL_LO 8
`define SFOC_B_RISE_EN 7
`define SFOC_F_RISE_HI 6
`define SFOC_F_RISE_LO 0
`define SFOC_B_BIN 15
`define SFOC_B_ZEN 13
`define SFOC_F_ZOOM_HI 12
`define SFOC_F_ZOOM_LO 11
`define SFOC_B_ADC1 10
`define SFOC_B_CTX 3
`define SFOC_DEF_LEAD 24'h000006
`define SFOC_DEF_TAIL 24'h000006
`define SFOC_EARLY_CONST 24'h000003
`endif

// ==== verilog/sfoc_frame_ctrl.v ====
`timescale 1ns/1ps
`include "sfoc_regs.vh"

module sfoc_fifo #(
   parameter W = 10,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire [W-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [W-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rp_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk_sys) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // sfoc_fifo

module sfoc_frame_ctrl #(
   parameter ROWS = 24'd1200,
   parameter COLS = 24'd1600,
   parameter HBLANK = 24'd200,
   parameter VBLANK = 24'd1000,
   parameter INTEG = 24'd5000,
   parameter FIFO_DEPTH = 8
) (
   input wire clk_sys,
   input wire sys_rst,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata,
   output reg [15:0] reg_rdata_q,
   input wire pix_clk,
   input wire [9:0] pix_in_data,
   input wire pix_in_valid,
   output wire pix_in_ready,
   output reg frame_valid_q,
   output reg line_valid_q,
   output reg [9:0] pix_dout_q,
   output wire low_power,
   output wire bin_mode,
   output wire one_adc_mode,
   output wire hung
);
   localparam S_IDLE = 3'h0;
   localparam S_WAIT = 3'h1;
   localparam S_LEAD = 3'h2;
   localparam S_LINE = 3'h3;
   localparam S_HBL = 3'h4;
   localparam S_TAIL = 3'h5;
   localparam S_VBL = 3'h6;
   localparam [23:0] ROWT = COLS + HBLANK;
   localparam [23:0] TO_END0 = ROWS * ROWT - HBLANK;

   // Zoom code to factor; 1 when zoom is off
   function [4:0] zoom_of;
      input en;
      input [1:0] f;
      begin
         if (!en) begin
            zoom_of = 5'h01;
         end else begin
            case (f)
               2'h0: zoom_of = 5'h02;
               2'h1: zoom_of = 5'h04;
               2'h2: zoom_of = 5'h08;
               default: zoom_of = 5'h10;
            endcase
         end
      end
   endfunction

   reg [15:0] rst_reg_q;
   reg [15:0] strobe_reg_q;
   reg [15:0] rmb_reg_q;
   reg [15:0] ctx_reg_q;
   reg restart_q;
   reg hang_q;
   reg pclk_s1_q;
   reg pclk_s2_q;
   reg pclk_s3_q;
   reg half_q;
   reg [2:0] st_q;
   reg [23:0] cnt_q;
   reg [23:0] to_end_q;
   reg [23:0] row_q;
   reg [4:0] zidx_q;
   reg [4:0] hold_q;
   reg blank_q;
   reg bad_q;
   reg [4:0] act_q;
   wire softrst;
   wire standby;
   wire run;
   wire hang_hit;
   wire [4:0] pend;
   wire [4:0] zoom;
   wire tick;
   wire [23:0] lead_rise;
   wire [23:0] lead_fall;
   wire fifo_valid;
   wire [9:0] fifo_data;
   wire pop;
   wire last_row;
   wire line_go;
   wire next_blank;

   assign softrst = rst_reg_q[`SFOC_B_SOFTRST];
   assign standby = rst_reg_q[`SFOC_B_STBY];
   assign low_power = standby;
   assign hung = hang_q;
   assign run = ~softrst & ~standby & ~hang_q;
   assign hang_hit = (reg_wr | reg_rd) & standby &
      (reg_addr >= `SFOC_HANG_LO) & (reg_addr <= `SFOC_HANG_HI);

   // Context B fields only when selected; context A is read as normal readout
   assign pend = ctx_reg_q[`SFOC_B_CTX] ? {rmb_reg_q[`SFOC_B_BIN], rmb_reg_q[`SFOC_B_ZEN],
      rmb_reg_q[`SFOC_F_ZOOM_HI:`SFOC_F_ZOOM_LO], rmb_reg_q[`SFOC_B_ADC1]} : 5'h00;
   assign bin_mode = act_q[4];
   assign one_adc_mode = act_q[0];
   assign zoom = zoom_of(act_q[3], act_q[2:1]);

   assign lead_rise = strobe_reg_q[`SFOC_B_RISE_EN] ?
      ({17'h00000, strobe_reg_q[`SFOC_F_RISE_HI:`SFOC_F_RISE_LO]} + 24'h000001) * ROWT
      + HBLANK + `SFOC_EARLY_CONST : `SFOC_DEF_LEAD;
   assign lead_fall = ({17'h00000, strobe_reg_q[`SFOC_F_FALL_HI:`SFOC_F_FALL_LO]}
      + 24'h000001) * ROWT + `SFOC_EARLY_CONST;

   // Register port; soft reset holds every other field at its default
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         rst_reg_q <= `SFOC_RST_DEFAULT;
         strobe_reg_q <= `SFOC_STROBE_DEFAULT;
         rmb_reg_q <= `SFOC_RMB_DEFAULT;
         ctx_reg_q <= `SFOC_CTX_DEFAULT;
         restart_q <= 1'b0;
         hang_q <= 1'b0;
         reg_rdata_q <= 16'h0000;
      end else begin
         restart_q <= 1'b0;
         if (hang_hit) begin
            hang_q <= 1'b1;
         end
         if (reg_wr & ~hang_q & ~hang_hit) begin
            case (reg_addr)
               `SFOC_ADDR_RESET: begin
                  rst_reg_q <= {reg_wdata[`SFOC_B_HOLD], 6'h00, reg_wdata[`SFOC_B_SHOWBAD],
                     5'h00, reg_wdata[`SFOC_B_STBY], 1'b0, reg_wdata[`SFOC_B_SOFTRST]};
                  restart_q <= reg_wdata[`SFOC_B_RESTART];
               end
               `SFOC_ADDR_STROBE: strobe_reg_q <= reg_wdata;
               `SFOC_ADDR_RMB: rmb_reg_q <= {reg_wdata[15], 1'b0, reg_wdata[13:10], 10'h000};
               `SFOC_ADDR_CTXSEL: ctx_reg_q <= {12'h000, reg_wdata[`SFOC_B_CTX], 3'h0};
               default: ;
            endcase
         end
         if (softrst & ~(reg_wr & (reg_addr == `SFOC_ADDR_RESET))) begin
            rst_reg_q <= `SFOC_RST_DEFAULT | 16'h0001;
            strobe_reg_q <= `SFOC_STROBE_DEFAULT;
            rmb_reg_q <= `SFOC_RMB_DEFAULT;
            ctx_reg_q <= `SFOC_CTX_DEFAULT;
         end
         if (reg_rd) begin
            case (reg_addr)
               `SFOC_ADDR_RESET: reg_rdata_q <= rst_reg_q;
               `SFOC_ADDR_STROBE: reg_rdata_q <= strobe_reg_q;
               `SFOC_ADDR_RMB: reg_rdata_q <= rmb_reg_q;
               `SFOC_ADDR_CTXSEL: reg_rdata_q <= ctx_reg_q;
               default: reg_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // Pixel clock is sampled; it must be under half of clk_sys to be seen
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pclk_s1_q <= 1'b0;
         pclk_s2_q <= 1'b0;
         pclk_s3_q <= 1'b0;
         half_q <= 1'b0;
      end else begin
         pclk_s1_q <= pix_clk;
         pclk_s2_q <= pclk_s1_q;
         pclk_s3_q <= pclk_s2_q;
         if (pclk_s2_q & ~pclk_s3_q) begin
            half_q <= ~half_q;
         end
      end
   end
   // One converter: readout advances on every other pixel clock
   assign tick = pclk_s2_q & ~pclk_s3_q & (~act_q[0] | half_q);

   sfoc_fifo #(
      .W(10),
      .DEPTH(FIFO_DEPTH),
      .AW(3)
   ) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .in_data(pix_in_data),
      .in_valid(pix_in_valid),
      .in_ready(pix_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(pop)
   );

   // Blank rows carry no pixels, so the FIFO is only drained on real rows
   // First pixel leaves with the line strobe, so the closing tick drops nothing
   assign line_go = tick & (cnt_q <= 24'h000001) & ((st_q == S_LEAD) | (st_q == S_HBL));
   assign next_blank = (st_q == S_HBL) & (zidx_q != zoom - 5'h01);
   assign pop = run & ~restart_q & ((line_go & ~next_blank) | (tick & (st_q == S_LINE) &
      (hold_q == 5'h00) & ~blank_q & (cnt_q > 24'h000001)));
   assign last_row = (row_q == ROWS - 24'h000001);

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q <= S_IDLE;
         cnt_q <= 24'h000000;
         to_end_q <= 24'h000000;
         row_q <= 24'h000000;
         zidx_q <= 5'h00;
         hold_q <= 5'h00;
         blank_q <= 1'b0;
         bad_q <= 1'b0;
         act_q <= 5'h00;
         frame_valid_q <= 1'b0;
         line_valid_q <= 1'b0;
         pix_dout_q <= 10'h000;
      end else if (~run | restart_q) begin
         st_q <= run ? S_WAIT : S_IDLE;
         cnt_q <= INTEG;
         frame_valid_q <= 1'b0;
         line_valid_q <= 1'b0;
         pix_dout_q <= 10'h000;
         if (softrst) begin
            act_q <= 5'h00;
         end
      end else begin
         case (st_q)
            S_IDLE: begin
               st_q <= S_WAIT;
               cnt_q <= INTEG;
            end
            S_WAIT, S_VBL: begin
               if (tick) begin
                  if (cnt_q <= 24'h000001) begin
                     // Frame start: pending settings land here unless held
                     st_q <= S_LEAD;
                     cnt_q <= lead_rise;
                     to_end_q <= TO_END0;
                     row_q <= 24'h000000;
                     zidx_q <= 5'h00;
                     blank_q <= 1'b0;
                     if (~rst_reg_q[`SFOC_B_HOLD]) begin
                        act_q <= pend;
                        bad_q <= (pend != act_q) & ~rst_reg_q[`SFOC_B_SHOWBAD];
                        frame_valid_q <= ~((pend != act_q) & ~rst_reg_q[`SFOC_B_SHOWBAD]);
                     end else begin
                        bad_q <= 1'b0;
                        frame_valid_q <= 1'b1;
                     end
                  end else begin
                     cnt_q <= cnt_q - 24'h000001;
                  end
               end
            end
            S_LEAD: begin
               if (tick) begin
                  if (cnt_q <= 24'h000001) begin
                     st_q <= S_LINE;
                     cnt_q <= COLS;
                     hold_q <= zoom - 5'h01;
                     pix_dout_q <= (bad_q | ~fifo_valid) ? 10'h000 : fifo_data;
                     line_valid_q <= ~bad_q;
                  end else begin
                     cnt_q <= cnt_q - 24'h000001;
                  end
               end
            end
            S_LINE, S_HBL: begin
               if (tick) begin
                  to_end_q <= to_end_q - 24'h000001;
                  cnt_q <= cnt_q - 24'h000001;
                  if (strobe_reg_q[`SFOC_B_FALL_EN] & (to_end_q <= lead_fall + 24'h000001)) begin
                     frame_valid_q <= 1'b0;
                  end
                  if (st_q == S_LINE) begin
                     if (hold_q == 5'h00) begin
                        hold_q <= zoom - 5'h01;
                        pix_dout_q <= (blank_q | bad_q | ~fifo_valid) ? 10'h000 : fifo_data;
                     end else begin
                        hold_q <= hold_q - 5'h01;
                     end
                     if (cnt_q <= 24'h000001) begin
                        line_valid_q <= 1'b0;
                        pix_dout_q <= 10'h000;
                        st_q <= last_row ? S_TAIL : S_HBL;
                        cnt_q <= last_row ? `SFOC_DEF_TAIL : HBLANK;
                     end
                  end else if (cnt_q <= 24'h000001) begin
                     // Each real row is followed by zoom-1 blank rows of equal length
                     st_q <= S_LINE;
                     cnt_q <= COLS;
                     hold_q <= zoom - 5'h01;
                     pix_dout_q <= (next_blank | bad_q | ~fifo_valid) ? 10'h000 : fifo_data;
                     row_q <= row_q + 24'h000001;
                     zidx_q <= (zidx_q == zoom - 5'h01) ? 5'h00 : zidx_q + 5'h01;
                     blank_q <= (zidx_q != zoom - 5'h01);
                     line_valid_q <= ~bad_q;
                  end
               end
            end
            S_TAIL: begin
               if (tick) begin
                  if (cnt_q <= 24'h000001) begin
                     frame_valid_q <= 1'b0;
                     st_q <= S_VBL;
                     cnt_q <= VBLANK;
                  end else begin
                     cnt_q <= cnt_q - 24'h000001;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule // sfoc_frame_ctrl

// ==== verification/sfoc_frame_ctrl_sva.sv ====
`timescale 1ns/1ps
module sfoc_frame_ctrl_sva (
   input logic clk_sys,
   input logic sys_rst,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_addr,
   input logic [15:0] reg_wdata,
   input logic [15:0] reg_rdata_q,
   input logic pix_clk,
   input logic [9:0] pix_in_data,
   input logic pix_in_valid,
   input logic pix_in_ready,
   input logic frame_valid_q,
   input logic line_valid_q,
   input logic [9:0] pix_dout_q,
   input logic low_power,
   input logic bin_mode,
   input logic one_adc_mode,
   input logic hung
);
   logic [15:0] strobe_q;
   logic soft_q;
   logic [7:0] busy_q;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         strobe_q <= 16'h0000;
         soft_q <= 1'b0;
         busy_q <= 8'h00;
      end else begin
         if (soft_q)
            strobe_q <= 16'h0000;
         else if (reg_wr && reg_addr == 8'h30 && !hung)
            strobe_q <= reg_wdata;
         if (reg_wr && reg_addr == 8'h0D && !hung)
            soft_q <= reg_wdata[0];
         // Control writes reshape frames for a while, so strobe checks stand aside
         if (reg_wr && (reg_addr == 8'h0D || reg_addr == 8'h30))
            busy_q <= 8'hFF;
         else if (busy_q != 8'h00)
            busy_q <= busy_q - 8'h01;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   sequence s_lv_lead;
      ##[46:50] $rose(line_valid_q);
   endsequence
   sequence s_lv_run;
      line_valid_q [*7];
   endsequence
   idle_data_a: assert property (!line_valid_q |-> pix_dout_q == 10'h000)
      else $error("data not zero outside a line");
   restart_rd_a: assert property (reg_rd && reg_addr == 8'h0D |=> !reg_rdata_q[1])
      else $error("restart bit read back as one");
   strobe_rb_a: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata_q == strobe_q)
      else $error("timing register readback wrong");
   lowpow_set_a: assert property (reg_wr && reg_addr == 8'h0D && !hung && !soft_q
      && !reg_wdata[0] |=> low_power == $past(reg_wdata[2]))
      else $error("low power does not follow its bit");
   hang_acc_a: assert property ((reg_wr || reg_rd) && low_power && reg_addr >= 8'hF7
      && reg_addr <= 8'hFD |=> hung)
      else $error("forbidden access did not hang");
   hang_stick_a: assert property (hung |=> hung)
      else $error("hang cleared without reset");
   soft_idle_a: assert property (soft_q [*3] |-> !frame_valid_q && !line_valid_q)
      else $error("strobes active in soft reset");
   lv_run_a: assert property ($rose(line_valid_q) && busy_q == 8'h00 |=> s_lv_run)
      else $error("line strobe too short");
   rise_lead_a: assert property ($rose(frame_valid_q) && !strobe_q[7] && !one_adc_mode
      && busy_q == 8'h00 |-> s_lv_lead)
      else $error("frame lead not six ticks");
   lv_in_fv_a: assert property (line_valid_q && !strobe_q[15] && busy_q == 8'h00
      |-> frame_valid_q)
      else $error("frame strobe fell before last line");
endmodule // sfoc_frame_ctrl_sva

// ==== verification/sfoc_cam_rx.sv ====
`timescale 1ns/1ps
module sfoc_cam_rx (
   input logic clk_sys,
   input logic sys_rst,
   input logic frame_valid_q,
   input logic line_valid_q,
   input logic [9:0] pix_dout_q,
   output int frames,
   output int lead,
   output int tail,
   output int lines,
   output int dlines,
   output int lv_min,
   output int chg
);
   int c, t_fv, t_lv, t_lvf, t_fvf, ln, dl, mn, ch;
   logic fv_p, lv_p, arm, dat;
   logic [9:0] pd_p;
   always @(posedge clk_sys) begin
      c <= c + 1;
      fv_p <= frame_valid_q;
      lv_p <= line_valid_q;
      pd_p <= pix_dout_q;
      if (sys_rst) begin
         arm <= 1'b0;
         frames <= 0;
      end else begin
         if (frame_valid_q && !fv_p) begin
            t_fv <= c;
            ln <= 0;
            dl <= 0;
            mn <= 1000000;
            ch <= 0;
            arm <= 1'b1;
         end
         // Pixel changes inside lines reveal how long each pixel is held
         if (line_valid_q && lv_p && pix_dout_q != pd_p)
            ch <= ch + 1;
         if (!frame_valid_q && fv_p)
            t_fvf <= c;
         if (line_valid_q && !lv_p) begin
            if (ln == 0)
               lead <= c - t_fv;
            ln <= ln + 1;
            t_lv <= c;
            dat <= 1'b0;
         end
         if (line_valid_q && pix_dout_q != 10'h000)
            dat <= 1'b1;
         if (!line_valid_q && lv_p) begin
            t_lvf <= c;
            dl <= dl + int'(dat);
            if (c - t_lv < mn)
               mn <= c - t_lv;
         end
         // A gap longer than line blanking closes the frame, also after an early fall
         if (arm && !frame_valid_q && !fv_p && !line_valid_q && !lv_p && c - t_lvf > 28) begin
            arm <= 1'b0;
            frames <= frames + 1;
            tail <= t_fvf - t_lvf;
            lines <= ln;
            dlines <= dl;
            lv_min <= mn;
            chg <= ch;
         end
      end
   end
endmodule // sfoc_cam_rx

// ==== verification/sfoc_frame_ctrl_tb.sv ====
`timescale 1ns/1ps
module sfoc_frame_ctrl_tb;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic pix_clk = 1'b0;
   logic src_en = 1'b1;
   logic rdy_p = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [9:0] pix_in_data = 10'h200;
   wire [15:0] reg_rdata_q;
   wire [9:0] pix_dout_q;
   wire pix_in_ready, frame_valid_q, line_valid_q, low_power, bin_mode, one_adc_mode, hung;
   int frames, lead, tail, lines, dlines, lv_min, chg, n;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;
   always #25 clk_sys = ~clk_sys;
   initial begin
      #137;
      forever #200 pix_clk = ~pix_clk;
   end
   sfoc_frame_ctrl #(.ROWS(24'd4), .COLS(24'd8), .HBLANK(24'd3), .VBLANK(24'd4), .INTEG(24'd2))
   sfoc_frame_ctrl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .pix_clk(pix_clk),
      .pix_in_data(pix_in_data), .pix_in_valid(src_en), .pix_in_ready(pix_in_ready),
      .frame_valid_q(frame_valid_q), .line_valid_q(line_valid_q), .pix_dout_q(pix_dout_q),
      .low_power(low_power), .bin_mode(bin_mode), .one_adc_mode(one_adc_mode), .hung(hung));
   sfoc_cam_rx sfoc_cam_rx_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .frame_valid_q(frame_valid_q),
      .line_valid_q(line_valid_q), .pix_dout_q(pix_dout_q), .frames(frames), .lead(lead),
      .tail(tail), .lines(lines), .dlines(dlines), .lv_min(lv_min), .chg(chg));
   task summarize;
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge clk_sys) begin
      // The word is taken at the edge after ready was seen, so advance one cycle late
      if (rdy_p && src_en)
         pix_in_data <= {1'b1, pix_in_data[8:0] + 9'h001};
      rdy_p <= pix_in_ready;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors = errors + 1;
         summarize();
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [15:0] e);
      @(negedge clk_sys);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk("reg_rdata_q", {16'h0000, reg_rdata_q}, {16'h0000, e});
   endtask
   // Two completions: the first may still be the frame that was running at the change
   task frm2;
      int f;
      int k;
      repeat (2) begin
         f = frames;
         k = 0;
         while (frames == f && k < 4000) begin
            @(negedge clk_sys);
            k = k + 1;
         end
         if (k == 4000) begin
            errors = errors + 1;
            summarize();
         end
      end
   endtask
   task fchk(input int ld, input int tl, input int dl, input int lv);
      chk("lead", lead, ld);
      chk("tail", tail, tl);
      chk("lines", lines, 4);
      chk("dlines", dlines, dl);
      chk("lv_min", lv_min, lv);
   endtask
   initial begin
      repeat (16) @(negedge clk_sys);
      sys_rst = 1'b0;
      repeat (20) @(negedge clk_sys);
      chk("pix_in_ready", {31'h0, pix_in_ready}, 32'h0);
      rdc(8'h0D, 16'h0000);
      rdc(8'h30, 16'h0000);
      rdc(8'h20, 16'h0000);
      rdc(8'h44, 16'h0000);
      frm2;
      fchk(48, 48, 4, 64);
      chk("chg", chg, 28);
      wr(8'h30, 16'h0081);
      frm2;
      fchk(224, 48, 4, 64);
      wr(8'h30, 16'h8100);
      frm2;
      fchk(48, -200, 4, 64);
      wr(8'h30, 16'h0000);
      wr(8'h20, 16'h8000);
      frm2;
      chk("bin_mode", {31'h0, bin_mode}, 32'h0);
      wr(8'hF2, 16'h0008);
      frm2;
      chk("bin_mode", {31'h0, bin_mode}, 32'h1);
      for (n = 0; n < 4; n++) begin
         wr(8'h20, 16'h2000 | (16'(n) << 11));
         frm2;
         fchk(48, 48, (n == 0) ? 2 : 1, 64);
         chk("chg", chg, (n == 0) ? 6 : (n == 1) ? 1 : 0);
      end
      wr(8'h0D, 16'h8000);
      wr(8'h20, 16'h0000);
      frm2;
      fchk(48, 48, 1, 64);
      wr(8'h0D, 16'h0000);
      frm2;
      fchk(48, 48, 4, 64);
      wr(8'h20, 16'h0400);
      frm2;
      chk("one_adc_mode", {31'h0, one_adc_mode}, 32'h1);
      fchk(96, 96, 4, 128);
      wr(8'h20, 16'h0000);
      frm2;
      n = 0;
      while (!frame_valid_q && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("frame_valid_q", {31'h0, frame_valid_q}, 32'h1);
      repeat (60) @(negedge clk_sys);
      wr(8'h0D, 16'h0002);
      // The integration wait is only two ticks here, so look before the new frame starts
      repeat (2) @(negedge clk_sys);
      chk("frame_valid_q", {31'h0, frame_valid_q}, 32'h0);
      rdc(8'h0D, 16'h0000);
      frm2;
      fchk(48, 48, 4, 64);
      wr(8'h20, 16'hFFFF);
      rdc(8'h20, 16'hBC00);
      wr(8'h30, 16'h0081);
      wr(8'h0D, 16'h0001);
      repeat (4) @(negedge clk_sys);
      chk("line_valid_q", {31'h0, line_valid_q}, 32'h0);
      rdc(8'h30, 16'h0000);
      rdc(8'h20, 16'h0000);
      rdc(8'h0D, 16'h0001);
      wr(8'h0D, 16'h0000);
      frm2;
      fchk(48, 48, 4, 64);
      src_en = 1'b0;
      frm2;
      chk("dlines", dlines, 0);
      chk("pix_in_ready", {31'h0, pix_in_ready}, 32'h1);
      src_en = 1'b1;
      wr(8'h0D, 16'h0004);
      chk("low_power", {31'h0, low_power}, 32'h1);
      rdc(8'hF8, 16'h0000);
      chk("hung", {31'h0, hung}, 32'h1);
      repeat (200) @(negedge clk_sys);
      n = frames;
      repeat (1500) @(negedge clk_sys);
      chk("frames", frames, n);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      chk("hung", {31'h0, hung}, 32'h0);
      summarize();
   end
endmodule // sfoc_frame_ctrl_tb
bind sfoc_frame_ctrl sfoc_frame_ctrl_sva sfoc_frame_ctrl_sva_i (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .pix_clk(pix_clk),
   .pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
   .frame_valid_q(frame_valid_q), .line_valid_q(line_valid_q), .pix_dout_q(pix_dout_q),
   .low_power(low_power), .bin_mode(bin_mode), .one_adc_mode(one_adc_mode), .hung(hung));
